// [hdl/rfstq_pkg.sv]
package rfstq_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  RX_HEAD_FRAME_STATUS_OFS = 8'h7c;
  localparam logic [7:0]  RX_HEAD_FRAME_LENGTH_OFS = 8'h7e;
  localparam logic [7:0]  TX_QUEUE_COMMAND_OFS     = 8'h80;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int FRAME_VALID_BIT   = 15;
  localparam int ICMP_CSUM_BIT     = 13;
  localparam int IP_CSUM_BIT       = 12;
  localparam int TCP_CSUM_BIT      = 11;
  localparam int UDP_CSUM_BIT      = 10;
  localparam int BROADCAST_BIT     = 7;
  localparam int MULTICAST_BIT     = 6;
  localparam int UNICAST_BIT       = 5;
  localparam int MEDIA_ERR_BIT     = 4;
  localparam int FRAME_TYPE_BIT    = 3;
  localparam int TOO_LONG_BIT      = 2;
  localparam int RUNT_BIT          = 1;
  localparam int CRC_ERR_BIT       = 0;

  // ---------------------------------------------------------------
  // command field positions and widths
  // ---------------------------------------------------------------
  localparam int TX_MEM_MONITOR_BIT = 1;
  localparam int MANUAL_ENQUEUE_BIT = 0;
  localparam int BYTE_COUNT_W       = 12;
  localparam int TX_FREE_W          = 13;
  localparam int ISR_MEM_AVAIL_BIT  = 6;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [15:0] STATUS_RST       = 16'h0000;
  localparam logic [15:0] CMD_RST          = 16'h0000;
  localparam logic [15:0] ETHERTYPE_MIN    = 16'h05dc;
  localparam logic [11:0] TOO_LONG_BYTES   = 12'h7d0;

  typedef enum logic [1:0] {
    RFSTQ_TX_IDLE = 2'b00,
    RFSTQ_TX_BUSY = 2'b01
  } rfstq_tx_state_type;

endpackage

// [hdl/rfstq_regs.sv]
`timescale 1ns/100ps
module rfstq_regs (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ack,
  // receive side: frame end report
  input  wire logic        i_rx_frame_done,
  input  wire logic        i_rx_receiving,
  input  wire logic [11:0] i_rx_length,
  input  wire logic [15:0] i_rx_type_len,
  input  wire logic [47:0] i_rx_dest_addr,
  input  wire logic        i_rx_icmp_bad,
  input  wire logic        i_rx_ip_bad,
  input  wire logic        i_rx_tcp_bad,
  input  wire logic        i_rx_udp_bad,
  input  wire logic        i_rx_symbol_err,
  input  wire logic        i_rx_runt,
  input  wire logic        i_rx_crc_err,
  input  wire logic        i_pass_bad_frame,
  input  wire logic        i_rx_head_pop,
  input  wire logic        i_rx_queue_empty,
  output logic             o_rx_frame_accept,
  output logic             o_rx_frame_drop,
  // transmit side
  input  wire logic [12:0] i_tx_free_bytes,
  input  wire logic [12:0] i_next_tx_frame_size,
  input  wire logic        i_tx_frame_done,
  output logic             o_tx_enqueue,
  output logic             o_isr_mem_avail_set
);

  typedef struct packed {
    logic [15:0]                     cmd;
    logic                            mem_armed;
    rfstq_pkg::rfstq_tx_state_type   tx_state;
    logic [15:0]                     rdata;
    logic                            ack;
    logic                            isr_set;
    logic                            enq_pulse;
  } rfstq_regs_type;

  rfstq_regs_type state_reg;
  rfstq_regs_type state_next;

  logic [15:0] new_status;
  logic        bad_frame;
  logic        accept;
  logic        head_load;
  logic        head_clear;
  logic [15:0] head_status;
  logic [11:0] head_count;
  logic        is_bcast;
  logic        is_mcast;
  logic        too_long;

  // ---------------------------------------------------------------
  // receive status build
  // ---------------------------------------------------------------
  always_comb begin
    is_bcast   = (i_rx_dest_addr == 48'hffff_ffff_ffff);
    is_mcast   = i_rx_dest_addr[40];
    too_long   = (i_rx_length > rfstq_pkg::TOO_LONG_BYTES);
    new_status = rfstq_pkg::STATUS_RST;
    new_status[rfstq_pkg::FRAME_VALID_BIT] = 1'b1;
    new_status[rfstq_pkg::ICMP_CSUM_BIT]   = i_rx_icmp_bad;
    new_status[rfstq_pkg::IP_CSUM_BIT]     = i_rx_ip_bad;
    new_status[rfstq_pkg::TCP_CSUM_BIT]    = i_rx_tcp_bad;
    new_status[rfstq_pkg::UDP_CSUM_BIT]    = i_rx_udp_bad;
    new_status[rfstq_pkg::BROADCAST_BIT]   = is_bcast;
    new_status[rfstq_pkg::MULTICAST_BIT]   = is_mcast;
    new_status[rfstq_pkg::UNICAST_BIT]     = !is_mcast;
    new_status[rfstq_pkg::MEDIA_ERR_BIT]   = i_rx_symbol_err;
    new_status[rfstq_pkg::FRAME_TYPE_BIT]  =
      (i_rx_type_len > rfstq_pkg::ETHERTYPE_MIN);
    new_status[rfstq_pkg::TOO_LONG_BIT]    = too_long;
    new_status[rfstq_pkg::RUNT_BIT]        = i_rx_runt;
    new_status[rfstq_pkg::CRC_ERR_BIT]     = i_rx_crc_err;
    bad_frame  = too_long || i_rx_runt || i_rx_crc_err;
    accept     = i_rx_frame_done && (!bad_frame || i_pass_bad_frame);
  end

  // head latch loads the accepted frame when the queue held none or its head is popped in the same cycle
  assign head_load  = accept && (i_rx_queue_empty || i_rx_head_pop);
  assign head_clear = i_rx_head_pop || i_rx_receiving;

  rfstq_status_latch u_head (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_load    (head_load),
    .i_clear   (head_clear),
    .i_status  (new_status),
    .i_count   (i_rx_length),
    .o_status  (head_status),
    .o_count   (head_count)
  );

  assign o_rx_frame_accept = accept;
  assign o_rx_frame_drop   = i_rx_frame_done && !accept;

  // ---------------------------------------------------------------
  // register access and transmit command
  // ---------------------------------------------------------------
  always_comb begin
    state_next           = state_reg;
    state_next.ack       = 1'b0;
    state_next.isr_set   = 1'b0;
    state_next.enq_pulse = 1'b0;

    // reads are non-destructive, repeatable per frame
    if (i_reg_rd) begin
      state_next.ack = 1'b1;
      if (i_reg_addr == rfstq_pkg::RX_HEAD_FRAME_STATUS_OFS) begin
        state_next.rdata = head_status;
      end else if (i_reg_addr == rfstq_pkg::RX_HEAD_FRAME_LENGTH_OFS) begin
        state_next.rdata = {4'h0, head_count};
      end else if (i_reg_addr == rfstq_pkg::TX_QUEUE_COMMAND_OFS) begin
        state_next.rdata = state_reg.cmd;
      end else begin
        state_next.rdata = 16'h0000;
      end
    end

    // transmit completion self-clears both command bits
    if (i_tx_frame_done && state_reg.tx_state == rfstq_pkg::RFSTQ_TX_BUSY) begin
      state_next.cmd[rfstq_pkg::MANUAL_ENQUEUE_BIT] = 1'b0;
      state_next.cmd[rfstq_pkg::TX_MEM_MONITOR_BIT] = 1'b0;
      state_next.tx_state = rfstq_pkg::RFSTQ_TX_IDLE;
    end

    // space watch, one isr event per arming; a new arming below wins
    if (state_reg.mem_armed && i_tx_free_bytes >= i_next_tx_frame_size) begin
      state_next.isr_set   = 1'b1;
      state_next.mem_armed = 1'b0;
    end

    if (i_reg_wr && i_reg_addr == rfstq_pkg::TX_QUEUE_COMMAND_OFS) begin
      state_next.ack = 1'b1;
      state_next.cmd[15:2] = i_reg_wdata[15:2];
      if (i_reg_wdata[rfstq_pkg::TX_MEM_MONITOR_BIT]) begin
        state_next.cmd[rfstq_pkg::TX_MEM_MONITOR_BIT] = 1'b1;
        state_next.mem_armed = 1'b1;
      end
      if (i_reg_wdata[rfstq_pkg::MANUAL_ENQUEUE_BIT] &&
          state_reg.tx_state == rfstq_pkg::RFSTQ_TX_IDLE) begin
        state_next.cmd[rfstq_pkg::MANUAL_ENQUEUE_BIT] = 1'b1;
        state_next.enq_pulse = 1'b1;
        state_next.tx_state  = rfstq_pkg::RFSTQ_TX_BUSY;
      end
    end else if (i_reg_wr) begin
      state_next.ack = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg.cmd       <= rfstq_pkg::CMD_RST;
      state_reg.mem_armed <= 1'b0;
      state_reg.tx_state  <= rfstq_pkg::RFSTQ_TX_IDLE;
      state_reg.rdata     <= 16'h0000;
      state_reg.ack       <= 1'b0;
      state_reg.isr_set   <= 1'b0;
      state_reg.enq_pulse <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign o_reg_rdata         = state_reg.rdata;
  assign o_reg_ack           = state_reg.ack;
  assign o_tx_enqueue        = state_reg.enq_pulse;
  assign o_isr_mem_avail_set = state_reg.isr_set;

endmodule // rfstq_regs

// [hdl/rfstq_status_latch.sv]
`timescale 1ns/100ps
module rfstq_status_latch (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_load,
  input  wire logic        i_clear,
  input  wire logic [15:0] i_status,
  input  wire logic [11:0] i_count,
  output logic      [15:0] o_status,
  output logic      [11:0] o_count
);

  typedef struct packed {
    logic [15:0] status;
    logic [11:0] count;
  } rfstq_latch_type;

  rfstq_latch_type state_reg;
  rfstq_latch_type state_next;

  // ---------------------------------------------------------------
  // head frame hold
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (i_load) begin
      state_next.status = i_status;
      state_next.count  = i_count;
    end else if (i_clear) begin
      state_next.status = rfstq_pkg::STATUS_RST;
      state_next.count  = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  assign o_status = state_reg.status;
  assign o_count  = state_reg.count;

endmodule // rfstq_status_latch

// [verif/rfstq_host_model.sv]
`timescale 1ns/100ps
module rfstq_host_model (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_rdata,
  input  wire logic        i_ack,
  output logic      [7:0]  o_addr,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'h0000;
  end
  // one-cycle strobe, answer taken while ack stands
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    @(posedge i_clk_sys); #1;
    o_addr = a;
    o_wdata = d;
    o_wr = w;
    o_rd = !w;
    @(posedge i_clk_sys); #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    n = 0;
    while (i_ack !== 1'b1 && n < 8) begin
      @(posedge i_clk_sys); #1;
      n++;
    end
    q = i_rdata;
    @(posedge i_clk_sys); #1;
  endtask
endmodule // rfstq_host_model

// [verif/rfstq_regs_sva.sv]
`timescale 1ns/100ps
module rfstq_regs_sva (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic [15:0] o_reg_rdata,
  input  wire logic        o_reg_ack,
  input  wire logic        i_rx_frame_done,
  input  wire logic [11:0] i_rx_length,
  input  wire logic        i_rx_runt,
  input  wire logic        i_rx_crc_err,
  input  wire logic        i_pass_bad_frame,
  input  wire logic        o_rx_frame_accept,
  input  wire logic        o_rx_frame_drop,
  input  wire logic [12:0] i_tx_free_bytes,
  input  wire logic [12:0] i_next_tx_frame_size,
  input  wire logic        o_tx_enqueue,
  input  wire logic        o_isr_mem_avail_set
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic bad;
  assign bad = i_rx_runt | i_rx_crc_err | (i_rx_length > rfstq_pkg::TOO_LONG_BYTES);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_ACK: assert property (i_ce && (i_reg_rd || i_reg_wr) |=> o_reg_ack)
    else $error("no ack after access");
  AST_NO_ACK: assert property (i_ce && !(i_reg_rd || i_reg_wr) |=> !o_reg_ack)
    else $error("ack without access");
  AST_LEN_UPPER: assert property (i_ce && i_reg_rd && i_reg_addr == 8'h7e
    |=> o_reg_rdata[15:12] == 4'h0)
    else $error("byte count upper bits set");
  AST_ENQ_CAUSE: assert property (o_tx_enqueue |-> $past(i_reg_wr && i_reg_wdata[0]
    && i_reg_addr == rfstq_pkg::TX_QUEUE_COMMAND_OFS))
    else $error("enqueue without command");
  AST_ENQ_ONE: assert property (o_tx_enqueue |=> !o_tx_enqueue)
    else $error("enqueue longer than one cycle");
  AST_GOOD: assert property (i_rx_frame_done && !bad |-> o_rx_frame_accept && !o_rx_frame_drop)
    else $error("good frame not accepted");
  AST_BAD: assert property (i_rx_frame_done && bad && !i_pass_bad_frame
    |-> o_rx_frame_drop && !o_rx_frame_accept)
    else $error("bad frame not dropped");
  AST_IDLE: assert property (!i_rx_frame_done |-> !o_rx_frame_accept && !o_rx_frame_drop)
    else $error("accept without frame end");
  AST_ISR: assert property (o_isr_mem_avail_set
    |-> $past(i_tx_free_bytes) >= $past(i_next_tx_frame_size))
    else $error("memory event without space");
  C_DROP: cover property (i_rx_frame_done && o_rx_frame_drop);
  C_ENQ: cover property (o_tx_enqueue);
  C_ISR: cover property (o_isr_mem_avail_set);
endmodule // rfstq_regs_sva
bind rfstq_regs rfstq_regs_sva u_sva (.*);

// [verif/testbench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic        i_clk_sys = 1'b0, i_rst_n = 1'b0;
  logic [11:0] len = 12'h000;
  logic [15:0] tl = 16'h0000, rdata, wdata, q, e, m;
  logic [47:0] da = 48'h0;
  logic [12:0] free = 13'h0010, size = 13'h0100;
  logic [7:0]  addr;
  logic        wr, rd, ack, acc, drop, enq, interrupt_status_reg, ok, bad;
  logic        fd = 1'b0, rcv = 1'b0, icmp = 1'b0, ip = 1'b0, tcp = 1'b0, udp = 1'b0;
  logic        sym = 1'b0, runt = 1'b0, crc = 1'b0, pbf = 1'b0, pop = 1'b0, txd = 1'b0;
  logic        ce = 1'b1;
  int          n_mismatch = 0, check_count = 0, cyc = 0, n_enq = 0, n_isr = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  rfstq_host_model u_host (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .i_ack(ack),
    .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  rfstq_regs DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(ce), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_rx_frame_done(fd), .i_rx_receiving(rcv), .i_rx_length(len), .i_rx_type_len(tl),
    .i_rx_dest_addr(da), .i_rx_icmp_bad(icmp), .i_rx_ip_bad(ip), .i_rx_tcp_bad(tcp),
    .i_rx_udp_bad(udp), .i_rx_symbol_err(sym), .i_rx_runt(runt), .i_rx_crc_err(crc),
    .i_pass_bad_frame(pbf), .i_rx_head_pop(pop), .i_rx_queue_empty(1'b1),
    .o_rx_frame_accept(acc), .o_rx_frame_drop(drop), .i_tx_free_bytes(free),
    .i_next_tx_frame_size(size), .i_tx_frame_done(txd), .o_tx_enqueue(enq),
    .o_isr_mem_avail_set(interrupt_status_reg));
  task automatic stop_test;
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(negedge i_clk_sys) begin
    cyc++;
    if (enq === 1'b1) n_enq++;
    if (interrupt_status_reg === 1'b1) n_isr++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ---------------------------------------------------------------
  // random frame end with model of status word
  // ---------------------------------------------------------------
  task automatic frame;
    @(posedge i_clk_sys); #1;
    len = 12'($urandom);
    tl = 16'($urandom);
    da = 48'({$urandom, $urandom});
    if ($urandom_range(3) == 0) da = '1;
    {icmp, ip, tcp, udp, sym, runt, crc, pbf} = 8'($urandom);
    fd = 1'b1;
    bad = runt | crc | (len > 12'h7d0);
    ok = !bad | pbf;
    e = {1'b1, 1'b0, icmp, ip, tcp, udp, 2'b00, &da, da[40], !da[40], sym,
         tl > 16'h05dc, len > 12'h7d0, runt, crc};
    if (!ok) e = 16'h0000;
    #1;
    `CHK({acc, drop}, {ok, !ok})
    @(posedge i_clk_sys); #1;
    fd = 1'b0;
  endtask
  initial begin
    void'($urandom(32'h5aaa));
    repeat (4) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    u_host.xfer(1'b0, 8'h7c, 16'h0, q);
    `CHK(q, 16'h0000)
    for (int i = 0; i < 40; i++) begin
      frame();
      m = e[1] ? 16'hfff7 : 16'hffff;
      u_host.xfer(1'b0, 8'h7c, 16'h0, q);
      `CHK(q & m, e & m)
      u_host.xfer(1'b0, 8'h7e, 16'h0, q);
      if (ok) `CHK(q, {4'h0, len})
      @(posedge i_clk_sys); #1;
      if (i[0]) rcv = 1'b1;
      else pop = 1'b1;
      @(posedge i_clk_sys); #1;
      {rcv, pop} = 2'b00;
      u_host.xfer(1'b0, 8'h7c, 16'h0, q);
      `CHK(q[15], 1'b0)
    end
    while (free < 13'h0010) @(posedge i_clk_sys);
    u_host.xfer(1'b1, 8'h80, 16'h0001, q);
    u_host.xfer(1'b1, 8'h80, 16'h0003, q);
    `CHK(n_enq, 1)
    u_host.xfer(1'b0, 8'h80, 16'h0, q);
    `CHK(q, 16'h0003)
    `CHK(n_isr, 0)
    @(posedge i_clk_sys); #1;
    free = 13'h0100;
    repeat (4) @(posedge i_clk_sys);
    `CHK(n_isr, 1)
    #1;
    txd = 1'b1;
    @(posedge i_clk_sys); #1;
    txd = 1'b0;
    q = 16'hffff;
    for (int n = 0; n < 8 && q[1:0] != 2'b00; n++) u_host.xfer(1'b0, 8'h80, 16'h0, q);
    `CHK(q[1:0], 2'b00)
    ce = 1'b0;
    u_host.xfer(1'b1, 8'h80, 16'h0001, q);
    ce = 1'b1;
    u_host.xfer(1'b0, 8'h80, 16'h0, q);
    `CHK(q, 16'h0000)
    `CHK(n_enq, 1)
    u_host.xfer(1'b0, 8'h7a, 16'h0, q);
    `CHK(q, 16'h0000)
    stop_test();
  end
endmodule // testbench
